// [system_area_pkg.sv]
/*
 * constants, field layout and carrier types of the system-area parameter loader.
 * assumes one 50 MHz clock domain and a 512-byte memory held in flip-flops.
 */
// Functional notes
// - read/write response bytes 0x1ea/0x1eb, default 0xff
// - family identifier byte 0x1ec, default 0x00
// - frame waiting integer byte 0x1ed, default 0xe0
// - stored values used only when enable/check valid
// - protection settings apply right after rewrite
// - other parameters apply only after reload
// - serial self-reset command reloads delayed parameters
// - power off means both supplies absent
// - serial and 14443 addresses map one-to-one
// - block mode: sixteen-byte blocks, low nibble position
// - command processed fully, then response returned
// - byte ten times reads, byte eleven writes
package system_area_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int MEM_BYTES = 512;
    localparam int BLOCK_W = 5;
    localparam int POS_W = 4;

    // ************************************************************
    // system-area offsets
    // ************************************************************
    localparam logic [8:0] SYS_CODE_OFS = 9'h1e0;
    localparam logic [8:0] CARD_ID_OFS = 9'h1e2;
    localparam logic [8:0] RD_RESP_OFS = 9'h1ea;
    localparam logic [8:0] WR_RESP_OFS = 9'h1eb;
    localparam logic [8:0] FAMILY_OFS = 9'h1ec;
    localparam logic [8:0] FRAME_WAIT_OFS = 9'h1ed;
    localparam logic [8:0] HW_ONE_OFS = 9'h1fa;
    localparam logic [8:0] HW_TWO_OFS = 9'h1fb;
    localparam logic [8:0] TUNNEL_OFS = 9'h1fc;
    localparam logic [8:0] PROTECT_OFS = 9'h1fd;
    localparam logic [8:0] CFG_EN_OFS = 9'h1fe;
    localparam logic [8:0] CFG_CHK_OFS = 9'h1ff;

    // ************************************************************
    // protection byte fields and validity codes
    // ************************************************************
    localparam int RF_RO_BIT = 0;
    localparam int SER_RO_BIT = 1;
    localparam int SEC_BIT = 2;
    localparam logic [7:0] CFG_EN_VALID = 8'ha5;
    localparam logic [7:0] CFG_CHK_XOR = 8'hff;

    // ************************************************************
    // defaults
    // ************************************************************
    localparam logic [15:0] SYS_CODE_DEF = 16'haaff;
    localparam logic [63:0] CARD_ID_DEF = 64'h02fe000000000000;
    localparam logic [7:0] RESP_DEF = 8'hff;
    localparam logic [7:0] FAMILY_DEF = 8'h00;
    localparam logic [7:0] FRAME_WAIT_DEF = 8'he0;
    localparam logic [7:0] HW_DEF = 8'h00;
    localparam logic [7:0] TUNNEL_DEF = 8'h00;
    localparam logic [7:0] PROTECT_DEF = 8'h00;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef enum logic [1:0] {MODE_SERIAL, MODE_ISO14443, MODE_BLOCK} access_mode_e;

    typedef struct packed {
        logic we;
        access_mode_e mode;
        logic [8:0] addr;
        logic [4:0] block;
        logic [3:0] pos;
        logic [7:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic [15:0] systemCode;
        logic [63:0] cardIdent;
        logic [7:0] readRespTime;
        logic [7:0] writeRespTime;
        logic [7:0] appFamilyIdent;
        logic [7:0] frameWaitInteger;
        logic [7:0] hardwareParamOne;
        logic [7:0] hardwareParamTwo;
        logic [7:0] tunnelTimeoutParam;
    } delayed_params_s;

    typedef struct packed {
        logic rfReadOnly;
        logic serialReadOnly;
        logic security;
    } immediate_params_s;

    localparam delayed_params_s DELAYED_DEF = '{systemCode: SYS_CODE_DEF, cardIdent: CARD_ID_DEF,
        readRespTime: RESP_DEF, writeRespTime: RESP_DEF, appFamilyIdent: FAMILY_DEF,
        frameWaitInteger: FRAME_WAIT_DEF, hardwareParamOne: HW_DEF, hardwareParamTwo: HW_DEF,
        tunnelTimeoutParam: TUNNEL_DEF};

endpackage

// [system_area_param_loader.sv]
/*
 * system-area parameter loader: memory command port, address mapping,
 * immediate protection settings and shadowed delayed-effect parameters.
 * assumes commands from logic on clk_sys; supply-present levels arrive from pins.
 */
module system_area_param_loader (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // memory command
    input wire logic reqValid,
    input wire system_area_pkg::mem_req_s req,
    // reload sources
    input wire logic selfResetCmd,
    input wire logic externalSupply,
    input wire logic rfSupply,
    // response
    output logic respValid_q,
    output logic [7:0] respData_q,
    output logic respError_q,
    output logic [8:0] respAddr_q,
    output logic [7:0] respTime_q,
    // active settings
    output system_area_pkg::delayed_params_s delayed_q,
    output system_area_pkg::immediate_params_s immediate_q,
    output logic cfgValid_q
);

    // ************************************************************
    // storage and defaults
    // ************************************************************
    logic [7:0] mem_q [system_area_pkg::MEM_BYTES];

    function automatic logic [7:0] defaultByte(input int idx);
        logic [8:0] a;
        a = 9'(idx);
        if (a == system_area_pkg::SYS_CODE_OFS) return system_area_pkg::SYS_CODE_DEF[15:8];
        if (a == system_area_pkg::SYS_CODE_OFS + 9'h001) return system_area_pkg::SYS_CODE_DEF[7:0];
        if (a == system_area_pkg::CARD_ID_OFS) return system_area_pkg::CARD_ID_DEF[63:56];
        if (a == system_area_pkg::CARD_ID_OFS + 9'h001) return system_area_pkg::CARD_ID_DEF[55:48];
        if (a == system_area_pkg::RD_RESP_OFS) return system_area_pkg::RESP_DEF;
        if (a == system_area_pkg::WR_RESP_OFS) return system_area_pkg::RESP_DEF;
        if (a == system_area_pkg::FRAME_WAIT_OFS) return system_area_pkg::FRAME_WAIT_DEF;
        return 8'h00;
    endfunction

    // ************************************************************
    // address mapping and access decode
    // ************************************************************
    wire logic [8:0] blockAddr = {req.block, req.pos};
    wire logic [8:0] physAddr = (req.mode == system_area_pkg::MODE_BLOCK) ? blockAddr : req.addr;
    wire logic isSerial = (req.mode == system_area_pkg::MODE_SERIAL);
    wire logic readOnly = isSerial ? immediate_q.serialReadOnly : immediate_q.rfReadOnly;
    wire logic writeOk = reqValid && req.we && !readOnly;
    wire logic refused = reqValid && req.we && readOnly;

    wire logic [7:0] enByte = mem_q[system_area_pkg::CFG_EN_OFS];
    wire logic [7:0] chkByte = mem_q[system_area_pkg::CFG_CHK_OFS];
    wire logic cfgValid = (enByte == system_area_pkg::CFG_EN_VALID) &&
                          (chkByte == (enByte ^ system_area_pkg::CFG_CHK_XOR));

    // ************************************************************
    // stored parameter image
    // ************************************************************
    system_area_pkg::delayed_params_s stored;
    assign stored.systemCode = {mem_q[system_area_pkg::SYS_CODE_OFS], mem_q[system_area_pkg::SYS_CODE_OFS + 9'h001]};
    assign stored.readRespTime = mem_q[system_area_pkg::RD_RESP_OFS];
    assign stored.writeRespTime = mem_q[system_area_pkg::WR_RESP_OFS];
    assign stored.appFamilyIdent = mem_q[system_area_pkg::FAMILY_OFS];
    assign stored.frameWaitInteger = mem_q[system_area_pkg::FRAME_WAIT_OFS];
    assign stored.hardwareParamOne = mem_q[system_area_pkg::HW_ONE_OFS];
    assign stored.hardwareParamTwo = mem_q[system_area_pkg::HW_TWO_OFS];
    assign stored.tunnelTimeoutParam = mem_q[system_area_pkg::TUNNEL_OFS];

    for (genvar i = 0; i < 8; i++) begin : g_ident
        assign stored.cardIdent[63 - 8 * i -: 8] = mem_q[system_area_pkg::CARD_ID_OFS + 9'(i)];
    end

    wire logic [7:0] protByte = cfgValid ? mem_q[system_area_pkg::PROTECT_OFS] : system_area_pkg::PROTECT_DEF;
    system_area_pkg::immediate_params_s immediate_d;
    assign immediate_d.rfReadOnly = protByte[system_area_pkg::RF_RO_BIT];
    assign immediate_d.serialReadOnly = protByte[system_area_pkg::SER_RO_BIT];
    assign immediate_d.security = protByte[system_area_pkg::SEC_BIT];

    // ************************************************************
    // supply sensing and reload events
    // ************************************************************
    logic extSync1_q, extSync2_q, rfSync1_q, rfSync2_q;
    logic offSeen_q, reloadPending_q;
    wire logic powerOff = !extSync2_q && !rfSync2_q;
    wire logic powerBack = offSeen_q && !powerOff;
    wire logic loadNow = reloadPending_q || powerBack || selfResetCmd;
    wire logic offSeen_d = powerOff ? 1'b1 : (loadNow ? 1'b0 : offSeen_q);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // running logic implies a supply; avoids a false power return after reset
            extSync1_q <= 1'b1;
            extSync2_q <= 1'b1;
            rfSync1_q <= 1'b1;
            rfSync2_q <= 1'b1;
            offSeen_q <= 1'b0;
            reloadPending_q <= 1'b1;
        end else begin
            extSync1_q <= externalSupply;
            extSync2_q <= extSync1_q;
            rfSync1_q <= rfSupply;
            rfSync2_q <= rfSync1_q;
            offSeen_q <= offSeen_d;
            reloadPending_q <= 1'b0;
        end
    end

    // ************************************************************
    // memory, shadows and response
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < system_area_pkg::MEM_BYTES; i++) begin
                mem_q[i] <= defaultByte(i);
            end
        end else if (writeOk) begin
            mem_q[physAddr] <= req.wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            delayed_q <= system_area_pkg::DELAYED_DEF;
            immediate_q <= '0;
            cfgValid_q <= 1'b0;
        end else begin
            if (loadNow) begin
                delayed_q <= cfgValid ? stored : system_area_pkg::DELAYED_DEF;
            end
            immediate_q <= immediate_d;
            cfgValid_q <= cfgValid;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            respValid_q <= 1'b0;
            respData_q <= 8'h00;
            respError_q <= 1'b0;
            respAddr_q <= 9'h000;
            respTime_q <= 8'h00;
        end else begin
            respValid_q <= reqValid;
            if (reqValid) begin
                respData_q <= req.we ? req.wdata : mem_q[physAddr];
                respError_q <= refused;
                respAddr_q <= physAddr;
                respTime_q <= req.we ? delayed_q.writeRespTime : delayed_q.readRespTime;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_resp_default;
        @(posedge clk_sys) disable iff (rst)
        loadNow && !cfgValid |=> delayed_q.readRespTime == 8'hff && delayed_q.writeRespTime == 8'hff;
    endproperty
    a_resp_default: assert property (p_resp_default) else $error("response bytes not defaulted");

    property p_family_default;
        @(posedge clk_sys) disable iff (rst)
        loadNow && !cfgValid |=> delayed_q.appFamilyIdent == 8'h00;
    endproperty
    a_family_default: assert property (p_family_default) else $error("family identifier not defaulted");

    property p_frame_wait_default;
        @(posedge clk_sys) disable iff (rst)
        loadNow && !cfgValid |=> delayed_q.frameWaitInteger == 8'he0;
    endproperty
    a_frame_wait_default: assert property (p_frame_wait_default) else $error("waiting integer not defaulted");

    property p_valid_load;
        @(posedge clk_sys) disable iff (rst)
        loadNow && cfgValid |=> delayed_q == $past(stored);
    endproperty
    a_valid_load: assert property (p_valid_load) else $error("stored values not taken");

    property p_immediate;
        @(posedge clk_sys) disable iff (rst)
        writeOk && physAddr == system_area_pkg::PROTECT_OFS && cfgValid
        |=> ##1 immediate_q.rfReadOnly == $past(req.wdata[0], 2) && immediate_q.security == $past(req.wdata[2], 2);
    endproperty
    a_immediate: assert property (p_immediate) else $error("protection not applied at once");

    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        !loadNow |=> $stable(delayed_q);
    endproperty
    a_hold: assert property (p_hold) else $error("delayed parameter changed without reload");

    property p_self_reset;
        @(posedge clk_sys) disable iff (rst)
        selfResetCmd && cfgValid |=> delayed_q.frameWaitInteger == $past(mem_q[system_area_pkg::FRAME_WAIT_OFS]);
    endproperty
    a_self_reset: assert property (p_self_reset) else $error("self-reset did not reload");

    property p_power_off;
        @(posedge clk_sys) disable iff (rst)
        (extSync2_q || rfSync2_q) && $past(extSync2_q || rfSync2_q) && !selfResetCmd && !reloadPending_q
        |-> !loadNow;
    endproperty
    a_power_off: assert property (p_power_off) else $error("reload while a supply stayed present");

    property p_linear_map;
        @(posedge clk_sys) disable iff (rst)
        reqValid && req.mode != system_area_pkg::MODE_BLOCK |=> respAddr_q == $past(req.addr);
    endproperty
    a_linear_map: assert property (p_linear_map) else $error("linear address translated");

    property p_block_map;
        @(posedge clk_sys) disable iff (rst)
        reqValid && req.mode == system_area_pkg::MODE_BLOCK
        |=> respAddr_q[8:4] == $past(req.block) && respAddr_q[3:0] == $past(req.pos);
    endproperty
    a_block_map: assert property (p_block_map) else $error("block address mismatch");

    property p_response;
        @(posedge clk_sys) disable iff (rst)
        reqValid |=> respValid_q ##1 (respValid_q == $past(reqValid));
    endproperty
    a_response: assert property (p_response) else $error("response not returned after command");

    property p_resp_time;
        @(posedge clk_sys) disable iff (rst)
        reqValid && !req.we |=> respTime_q == $past(delayed_q.readRespTime);
    endproperty
    a_resp_time: assert property (p_resp_time) else $error("read timing byte not used");

    c_self_reset: cover property (@(posedge clk_sys) disable iff (rst) selfResetCmd && cfgValid);
    c_power_cycle: cover property (@(posedge clk_sys) disable iff (rst) powerBack);
    c_block_read: cover property (@(posedge clk_sys) disable iff (rst)
        reqValid && !req.we && req.mode == system_area_pkg::MODE_BLOCK);
    c_refused: cover property (@(posedge clk_sys) disable iff (rst) refused);

endmodule

// [host_cmd_model.sv]
/*
 * command-issuing host or reader model for the system-area parameter loader.
 * assumes the loader takes a command on every rising clk_sys edge and answers one cycle later.
 */
module host_cmd_model (
    // clock
    input wire logic clk_sys,
    // command
    output logic reqValid,
    output system_area_pkg::mem_req_s req,
    output logic selfResetCmd,
    // response
    input wire logic respValid_q,
    input wire logic [7:0] respData_q,
    input wire logic respError_q,
    input wire logic [8:0] respAddr_q,
    input wire logic [7:0] respTime_q
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reqValid = 1'b0;
        req = '0;
        selfResetCmd = 1'b0;
    end

    // ************************************************************
    // one command per exchange, answer taken before the next
    // ************************************************************
    task automatic access(input logic we, input system_area_pkg::access_mode_e mode, input logic [8:0] addr,
        input logic [7:0] wdata, output logic v, output logic [7:0] d, output logic e, output logic [8:0] a,
        output logic [7:0] t);
        @(negedge clk_sys);
        reqValid = 1'b1;
        req.we = we;
        req.mode = mode;
        req.wdata = we ? wdata : ~wdata;
        // block mode carries block and position only; unused fields hold junk
        req.addr = (mode == system_area_pkg::MODE_BLOCK) ? ~addr : addr;
        req.block = (mode == system_area_pkg::MODE_BLOCK) ? addr[8:4] : ~addr[8:4];
        req.pos = (mode == system_area_pkg::MODE_BLOCK) ? addr[3:0] : ~addr[3:0];
        @(negedge clk_sys);
        reqValid = 1'b0;
        req = ~req;
        v = respValid_q;
        d = respData_q;
        e = respError_q;
        a = respAddr_q;
        t = respTime_q;
    endtask

    // ************************************************************
    // self-reset from the serial register-write command
    // ************************************************************
    task automatic self_reset();
        @(negedge clk_sys);
        selfResetCmd = 1'b1;
        @(negedge clk_sys);
        selfResetCmd = 1'b0;
    endtask
endmodule

// [testbench.sv]
/*
 * self-checking bench for the system-area parameter loader.
 * assumes the host model in host_cmd_model.sv and the loader package.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic externalSupply = 1'b1;
    logic rfSupply = 1'b0;
    logic reqValid, selfResetCmd, respValid_q, respError_q, cfgValid_q, v, e;
    system_area_pkg::mem_req_s req;
    logic [7:0] respData_q, respTime_q, d, t, curR, curW;
    logic [8:0] respAddr_q, a;
    system_area_pkg::delayed_params_s delayed_q;
    system_area_pkg::immediate_params_s immediate_q;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [8:0] ofs [4] = '{9'h1ea, 9'h1eb, 9'h1ec, 9'h1ed};
    logic [7:0] val [4] = '{8'h12, 8'h34, 8'h56, 8'h78};

    system_area_param_loader dut (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .req(req),
        .selfResetCmd(selfResetCmd), .externalSupply(externalSupply), .rfSupply(rfSupply),
        .respValid_q(respValid_q), .respData_q(respData_q), .respError_q(respError_q),
        .respAddr_q(respAddr_q), .respTime_q(respTime_q), .delayed_q(delayed_q),
        .immediate_q(immediate_q), .cfgValid_q(cfgValid_q));
    host_cmd_model u_host (.clk_sys(clk_sys), .reqValid(reqValid), .req(req), .selfResetCmd(selfResetCmd),
        .respValid_q(respValid_q), .respData_q(respData_q), .respError_q(respError_q),
        .respAddr_q(respAddr_q), .respTime_q(respTime_q));

    always #10 clk_sys = ~clk_sys;

    // ************************************************************
    // hang guard
    // ************************************************************
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic stop_test();
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [135:0] seen, input logic [135:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic acc(input logic we, input system_area_pkg::access_mode_e m, input logic [8:0] ad,
        input logic [7:0] wd);
        u_host.access(we, m, ad, wd, v, d, e, a, t);
        check("respValid", v, 1'b1);
        check("respAddr", a, ad);
    endtask

    task automatic wr(input system_area_pkg::access_mode_e m, input logic [8:0] ad, input logic [7:0] wd,
        input logic err);
        acc(1'b1, m, ad, wd);
        check("writeEcho", d, wd);
        check("writeError", e, err);
        check("writeTime", t, curW);
    endtask

    task automatic rd(input system_area_pkg::access_mode_e m, input logic [8:0] ad, input logic [7:0] exp);
        acc(1'b0, m, ad, 8'h00);
        check("readData", d, exp);
        check("readTime", t, curR);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        curR = 8'hff;
        curW = 8'hff;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("readRespDef", delayed_q.readRespTime, 8'hff);
        check("writeRespDef", delayed_q.writeRespTime, 8'hff);
        check("familyDef", delayed_q.appFamilyIdent, 8'h00);
        check("frameWaitDef", delayed_q.frameWaitInteger, 8'he0);
        check("cfgValidReset", cfgValid_q, 1'b0);
        rd(system_area_pkg::MODE_SERIAL, 9'h1ed, 8'he0);
        for (int i = 0; i < 4; i++) wr(system_area_pkg::MODE_SERIAL, ofs[i], val[i], 1'b0);
        for (int i = 0; i < 4; i++) rd(system_area_pkg::MODE_ISO14443, ofs[i], val[i]);
        for (int i = 0; i < 4; i++) rd(system_area_pkg::MODE_BLOCK, ofs[i], val[i]);
        u_host.self_reset();
        repeat (3) @(negedge clk_sys);
        check("invalidReload", delayed_q, system_area_pkg::DELAYED_DEF);
        wr(system_area_pkg::MODE_SERIAL, 9'h1e0, 8'h3c, 1'b0);
        wr(system_area_pkg::MODE_ISO14443, 9'h1e9, 8'h7e, 1'b0);
        wr(system_area_pkg::MODE_BLOCK, 9'h1fa, 8'h5d, 1'b0);
        wr(system_area_pkg::MODE_SERIAL, 9'h1fc, 8'h4b, 1'b0);
        wr(system_area_pkg::MODE_SERIAL, 9'h1fe, 8'ha5, 1'b0);
        wr(system_area_pkg::MODE_SERIAL, 9'h1ff, 8'h5a, 1'b0);
        repeat (2) @(negedge clk_sys);
        check("cfgValid", cfgValid_q, 1'b1);
        check("heldBeforeReload", delayed_q.readRespTime, 8'hff);
        check("codeHeld", delayed_q.systemCode, 16'haaff);
        u_host.self_reset();
        repeat (3) @(negedge clk_sys);
        check("selfResetRead", delayed_q.readRespTime, 8'h12);
        check("selfResetWrite", delayed_q.writeRespTime, 8'h34);
        check("selfResetFamily", delayed_q.appFamilyIdent, 8'h56);
        check("selfResetWait", delayed_q.frameWaitInteger, 8'h78);
        check("selfResetCode", delayed_q.systemCode, 16'h3cff);
        check("selfResetIdent", delayed_q.cardIdent, 64'h02fe00000000007e);
        check("selfResetHw", delayed_q.hardwareParamOne, 8'h5d);
        check("selfResetTunnel", delayed_q.tunnelTimeoutParam, 8'h4b);
        curR = 8'h12;
        curW = 8'h34;
        rd(system_area_pkg::MODE_BLOCK, 9'h1ea, 8'h12);
        wr(system_area_pkg::MODE_SERIAL, 9'h1fd, 8'h01, 1'b0);
        repeat (2) @(negedge clk_sys);
        check("rfReadOnly", immediate_q.rfReadOnly, 1'b1);
        wr(system_area_pkg::MODE_ISO14443, 9'h100, 8'haa, 1'b1);
        wr(system_area_pkg::MODE_BLOCK, 9'h101, 8'hbb, 1'b1);
        wr(system_area_pkg::MODE_SERIAL, 9'h102, 8'hcc, 1'b0);
        rd(system_area_pkg::MODE_SERIAL, 9'h100, 8'h00);
        rd(system_area_pkg::MODE_ISO14443, 9'h102, 8'hcc);
        wr(system_area_pkg::MODE_SERIAL, 9'h1fd, 8'h02, 1'b0);
        repeat (2) @(negedge clk_sys);
        check("serialReadOnly", immediate_q.serialReadOnly, 1'b1);
        wr(system_area_pkg::MODE_SERIAL, 9'h103, 8'h11, 1'b1);
        wr(system_area_pkg::MODE_ISO14443, 9'h1fd, 8'h04, 1'b0);
        repeat (2) @(negedge clk_sys);
        check("security", immediate_q.security, 1'b1);
        check("rfWritable", immediate_q.rfReadOnly, 1'b0);
        wr(system_area_pkg::MODE_SERIAL, 9'h1ed, 8'h9a, 1'b0);
        rfSupply = 1'b1;
        repeat (2) @(negedge clk_sys);
        externalSupply = 1'b0;
        repeat (6) @(negedge clk_sys);
        check("oneSupplyKept", delayed_q.frameWaitInteger, 8'h78);
        rfSupply = 1'b0;
        repeat (6) @(negedge clk_sys);
        externalSupply = 1'b1;
        repeat (6) @(negedge clk_sys);
        check("powerCycleReload", delayed_q.frameWaitInteger, 8'h9a);
        wr(system_area_pkg::MODE_SERIAL, 9'h1fe, 8'h00, 1'b0);
        u_host.self_reset();
        repeat (3) @(negedge clk_sys);
        check("disabledDefaults", delayed_q, system_area_pkg::DELAYED_DEF);
        check("securityDefault", immediate_q.security, 1'b0);
        stop_test();
    end
endmodule
